// ### verilog/csp_pkg.sv
package csp_pkg;

  // register byte offsets on the plain register port
  localparam logic [7:0] SUPPLY_MONITOR_CTRL_OFS  = 8'h0C;
  localparam logic [7:0] PROGRAM_STATUS_FLAGS_OFS = 8'hFC;
  localparam logic [7:0] GROUP_BANK_POINTER_OFS   = 8'hFD;
  localparam logic [7:0] STACK_TOP_POINTER_OFS    = 8'hFF;

  // status flag bit positions
  localparam int FLAG_USER_A_BIT  = 0;
  localparam int FLAG_USER_B_BIT  = 1;
  localparam int FLAG_HALF_BIT    = 2;
  localparam int FLAG_DECIMAL_BIT = 3;

  // supply monitor bit positions
  localparam int DETECT_ON_BIT  = 0;
  localparam int LVD_STATUS_BIT = 1;
  localparam int LVD_PAD_BIT    = 2;

  localparam logic [7:0] FLAGS_RESET        = 8'h00;
  localparam logic [7:0] GROUP_BANK_RESET   = 8'h00;
  localparam logic [7:0] STACK_RESET        = 8'h00;
  localparam logic [4:0] MONITOR_RSVD_VALUE = 5'h1F;

  // valid expanded banks
  localparam logic [3:0] BANK_ZERO = 4'h0;
  localparam logic [3:0] BANK_D    = 4'hD;
  localparam logic [3:0] BANK_F    = 4'hF;

  // settle time of the low-voltage flag after enabling
  localparam int LVD_SETTLE_US  = 20;
  localparam int CLK_MHZ        = 40;
  localparam int LVD_SETTLE_CYC = LVD_SETTLE_US * CLK_MHZ;

  // alu result flags for the bcd support bits
  typedef struct packed {
    logic valid;
    logic is_sub;
    logic half_carry;
  } csp_alu_evt_t;

  // stack operations
  typedef enum logic [1:0] {
    CSP_STK_NONE,
    CSP_STK_PUSH,
    CSP_STK_POP
  } csp_stk_op_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } csp_bus_req_t;

endpackage : csp_pkg

// ### verilog/csp_addr_former.sv
`timescale 1ns/10ps
`default_nettype none
module csp_addr_former (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] pointer_i,
  input  wire logic [3:0] work_reg_i,
  output logic      [7:0] work_addr_o,
  output logic      [3:0] bank_o,
  output logic            bank_valid_o
);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      work_addr_o <= 8'h00;
    end else begin
      work_addr_o <= {pointer_i[7:4], work_reg_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bank_o       <= 4'h0;
      bank_valid_o <= 1'b1;
    end else begin
      bank_o       <= pointer_i[3:0];
      // other banks are not built; flag them so the bus can see misuse
      bank_valid_o <= (pointer_i[3:0] == csp_pkg::BANK_ZERO) || (pointer_i[3:0] == csp_pkg::BANK_D)
                      || (pointer_i[3:0] == csp_pkg::BANK_F);
    end
  end

endmodule : csp_addr_former
`default_nettype wire

// ### verilog/csp_lvd_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module csp_lvd_monitor (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic enable_i,
  input  wire logic stop_mode_i,
  input  wire logic comparator_trip_i,
  output logic      status_o,
  output logic      settled_o
);

  logic [15:0] settle_reg;
  logic        active;

  assign active = enable_i && !stop_mode_i;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !active) begin
      settle_reg <= 16'h0000;
    end else if (settle_reg != 16'(csp_pkg::LVD_SETTLE_CYC)) begin
      settle_reg <= settle_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      settled_o <= 1'b0;
    end else begin
      settled_o <= active && (settle_reg == 16'(csp_pkg::LVD_SETTLE_CYC));
    end
  end

  // sticky until detection is switched off; software writes cannot touch it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !enable_i) begin
      status_o <= 1'b0;
    end else if (active && comparator_trip_i) begin
      status_o <= 1'b1;
    end
  end

endmodule : csp_lvd_monitor
`default_nettype wire

// ### verilog/csp_regs.sv
// Behaviour
// - decimal-adjust bit set after subtraction, cleared after addition
// - half-carry bit set on carry out of or borrow into bit 3
// - user bits change only on explicit writes, never jump conditions
// - half-carry and decimal-adjust bits not offered as jump conditions
// - working address is pointer upper nibble above 4-bit register number
// - upper nibble picks one of 16 groups of 16 registers
// - lower pointer nibble selects the expanded register bank
// - one 8-bit stack pointer addresses every push and pop
// - comparator trip sets the readable low-voltage status flag
// - supply monitor bit 0 enables detection, resets to 0
// - with detection on, request five comes only from detection
// - detection idle in stop mode even with bit 0 left set; no software action needed
`timescale 1ns/10ps
`default_nettype none
module csp_regs (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic [7:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [7:0]           rdata_o,
  input  wire csp_pkg::csp_alu_evt_t alu_evt_i,
  input  wire csp_pkg::csp_stk_op_t stk_op_i,
  input  wire logic [3:0]           work_reg_i,
  input  wire logic                 stop_mode_i,
  input  wire logic                 comparator_trip_i,
  input  wire logic                 pad_regulation_i,
  input  wire logic                 timer1_irq_i,
  output logic      [7:0]           work_addr_o,
  output logic      [3:0]           expanded_register_bank_o,
  output logic                      bank_valid_o,
  output logic      [7:0]           stack_addr_o,
  output logic                      interrupt_request_five_o,
  output logic                      lvd_settled_o
);

  logic [7:0] flags_reg;
  logic [7:0] group_bank_pointer_reg;
  logic [7:0] stack_top_pointer_reg;
  logic       low_voltage_detect_on_reg;
  logic       pad_regulation_status_reg;
  logic       low_voltage_status;
  logic [7:0] rdata_next;

  // user bits and the bcd bits are bus writable; only the bcd bits follow the alu
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flags_reg <= csp_pkg::FLAGS_RESET;
    end else begin
      if (wr_i && addr_i == csp_pkg::PROGRAM_STATUS_FLAGS_OFS) begin
        flags_reg <= wdata_i;
      end
      // an alu result in the same cycle wins over a write for the bcd bits
      // bcd bits only feed decimal adjust; no jump condition is taken from them
      if (alu_evt_i.valid) begin
        flags_reg[csp_pkg::FLAG_DECIMAL_BIT] <= alu_evt_i.is_sub;
        flags_reg[csp_pkg::FLAG_HALF_BIT]    <= alu_evt_i.half_carry;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      group_bank_pointer_reg <= csp_pkg::GROUP_BANK_RESET;
    end else if (wr_i && addr_i == csp_pkg::GROUP_BANK_POINTER_OFS) begin
      group_bank_pointer_reg <= wdata_i;
    end
  end

  // push pre-decrements, pop post-increments; the pointer wraps in 8 bits
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stack_top_pointer_reg <= csp_pkg::STACK_RESET;
    end else if (wr_i && addr_i == csp_pkg::STACK_TOP_POINTER_OFS) begin
      stack_top_pointer_reg <= wdata_i;
    end else begin
      unique case (stk_op_i)
        csp_pkg::CSP_STK_PUSH: stack_top_pointer_reg <= stack_top_pointer_reg - 8'h01;
        csp_pkg::CSP_STK_POP:  stack_top_pointer_reg <= stack_top_pointer_reg + 8'h01;
        csp_pkg::CSP_STK_NONE: stack_top_pointer_reg <= stack_top_pointer_reg;
        default:               stack_top_pointer_reg <= stack_top_pointer_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stack_addr_o <= 8'h00;
    end else if (stk_op_i == csp_pkg::CSP_STK_PUSH) begin
      stack_addr_o <= stack_top_pointer_reg - 8'h01;
    end else begin
      stack_addr_o <= stack_top_pointer_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      low_voltage_detect_on_reg <= 1'b0;
    end else if (wr_i && addr_i == csp_pkg::SUPPLY_MONITOR_CTRL_OFS) begin
      low_voltage_detect_on_reg <= wdata_i[csp_pkg::DETECT_ON_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pad_regulation_status_reg <= 1'b0;
    end else begin
      pad_regulation_status_reg <= pad_regulation_i;
    end
  end

  csp_lvd_monitor u_lvd (
    .clk_i             (clk_i),
    .sys_rst_i         (sys_rst_i),
    .enable_i          (low_voltage_detect_on_reg),
    .stop_mode_i       (stop_mode_i),
    .comparator_trip_i (comparator_trip_i),
    .status_o          (low_voltage_status),
    .settled_o         (lvd_settled_o)
  );

  csp_addr_former u_addr (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .pointer_i    (group_bank_pointer_reg),
    .work_reg_i   (work_reg_i),
    .work_addr_o  (work_addr_o),
    .bank_o       (expanded_register_bank_o),
    .bank_valid_o (bank_valid_o)
  );

  // timer 1 is cut off from request five while detection is on
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      interrupt_request_five_o <= 1'b0;
    end else if (low_voltage_detect_on_reg) begin
      interrupt_request_five_o <= low_voltage_status;
    end else begin
      interrupt_request_five_o <= timer1_irq_i;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    unique case (addr_i)
      csp_pkg::PROGRAM_STATUS_FLAGS_OFS: rdata_next = flags_reg;
      csp_pkg::GROUP_BANK_POINTER_OFS:   rdata_next = group_bank_pointer_reg;
      csp_pkg::STACK_TOP_POINTER_OFS:    rdata_next = stack_top_pointer_reg;
      csp_pkg::SUPPLY_MONITOR_CTRL_OFS:  rdata_next = {csp_pkg::MONITOR_RSVD_VALUE, pad_regulation_status_reg,
                                                       low_voltage_status, low_voltage_detect_on_reg};
      default:                           rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule : csp_regs
`default_nettype wire

// ### tb/csp_regs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module csp_regs_checker (
  input wire logic                 clk_i,
  input wire logic                 sys_rst_i,
  input wire logic [7:0]           addr_i,
  input wire logic [7:0]           wdata_i,
  input wire logic                 wr_i,
  input wire logic                 rd_i,
  input wire logic [7:0]           rdata_o,
  input wire csp_pkg::csp_stk_op_t stk_op_i,
  input wire logic [3:0]           work_reg_i,
  input wire logic                 stop_mode_i,
  input wire logic                 timer1_irq_i,
  input wire logic [7:0]           work_addr_o,
  input wire logic [3:0]           expanded_register_bank_o,
  input wire logic                 bank_valid_o,
  input wire logic [7:0]           stack_addr_o,
  input wire logic                 interrupt_request_five_o,
  input wire logic                 lvd_settled_o
);
  logic        en_q;
  logic        wp;
  logic        idl;
  logic        psh;
  logic [11:0] cnt;
  assign wp  = wr_i && addr_i == 8'hFD;
  assign idl = stk_op_i == csp_pkg::CSP_STK_NONE && !wr_i;
  assign psh = stk_op_i == csp_pkg::CSP_STK_PUSH && !wr_i;
  // mirror of the enable bit, since the checker cannot see inside
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) en_q <= 1'b0;
    else if (wr_i && addr_i == 8'h0C) en_q <= wdata_i[0];
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !en_q || stop_mode_i) cnt <= 12'h000;
    else if (cnt != 12'hFFF) cnt <= cnt + 12'h001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read");
  work_addr_a: assert property (wp ##1 !wp [*2] |=> work_addr_o == {$past(wdata_i[7:4], 3), $past(work_reg_i)})
    else $error("working address wrong");
  bank_sel_a: assert property (wp ##1 !wp [*2] |=> expanded_register_bank_o == $past(wdata_i[3:0], 3)
    && bank_valid_o == ($past(wdata_i[3:0], 3) inside {4'h0, 4'hD, 4'hF}))
    else $error("bank select wrong");
  irq_route_a: assert property (!$past(sys_rst_i) && !$past(en_q) |-> interrupt_request_five_o == $past(timer1_irq_i))
    else $error("request five not from timer while disabled");
  settle_time_a: assert property ($rose(lvd_settled_o) |-> cnt inside {[12'h31B:12'h325]})
    else $error("settle flag at wrong time");
  stack_push_a: assert property (idl [*3] ##1 psh ##1 idl [*3] |-> stack_addr_o == $past(stack_addr_o, 4) - 8'h01)
    else $error("push did not step stack address down");
  mon_read_a: assert property (rd_i && addr_i == 8'h0C |=> rdata_o[7:3] == 5'h1F && rdata_o[0] == $past(en_q))
    else $error("monitor read wrong");
  stat_off_a: assert property (rd_i && addr_i == 8'h0C && !en_q && !$past(en_q) |=> !rdata_o[1])
    else $error("status set while disabled");
endmodule : csp_regs_checker
`default_nettype wire

// ### tb/csp_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module csp_regs_tb;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, stop_mode_i = 1'b0;
  logic comparator_trip_i = 1'b0, pad_regulation_i = 1'b0, timer1_irq_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, work_addr_o, stack_addr_o, v, d;
  logic [3:0] work_reg_i = 4'h0, expanded_register_bank_o, b;
  logic bank_valid_o, interrupt_request_five_o, lvd_settled_o;
  logic [3:0] banks [3] = '{4'h0, 4'hD, 4'hF};
  csp_pkg::csp_alu_evt_t alu_evt_i = '0;
  csp_pkg::csp_stk_op_t  stk_op_i = csp_pkg::CSP_STK_NONE;
  int errors = 0, n_compared = 0, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  csp_regs csp_regs_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .alu_evt_i(alu_evt_i), .stk_op_i(stk_op_i), .work_reg_i(work_reg_i),
    .stop_mode_i(stop_mode_i), .comparator_trip_i(comparator_trip_i), .pad_regulation_i(pad_regulation_i),
    .timer1_irq_i(timer1_irq_i), .work_addr_o(work_addr_o), .expanded_register_bank_o(expanded_register_bank_o),
    .bank_valid_o(bank_valid_o), .stack_addr_o(stack_addr_o),
    .interrupt_request_five_o(interrupt_request_five_o), .lvd_settled_o(lvd_settled_o));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] dd);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= dd;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask : rd
  // pad bit follows the pad input a cycle late; the input is held long before any read
  function automatic logic [7:0] exp_mon(input logic en, input logic st);
    return {5'h1F, pad_regulation_i, st, en};
  endfunction : exp_mon
  task automatic close_out;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    void'($urandom(93));
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(8'hFD, v); chk(v, 8'h00, "pointer reset");
    rd(8'h0C, v); chk(v, exp_mon(0, 0), "monitor reset");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      b = 4'($urandom);
      wr(8'hFC, d);
      @(posedge clk_i);
      alu_evt_i <= {1'b1, b[0], b[1]};
      @(posedge clk_i);
      alu_evt_i <= '0;
      rd(8'hFC, v); chk(v, {d[7:4], b[0], b[1], d[1:0]}, "flags");
    end
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      if (i < 3) d[3:0] = banks[i];
      wr(8'hFD, d);
      @(posedge clk_i);
      work_reg_i <= 4'($urandom);
      pad_regulation_i <= 1'($urandom);
      repeat (2) @(posedge clk_i);
      #1 chk(work_addr_o, {d[7:4], work_reg_i}, "work address");
      chk({bank_valid_o, expanded_register_bank_o}, {d[3:0] inside {4'h0, 4'hD, 4'hF}, d[3:0]}, "bank");
      rd(8'hFD, v); chk(v, d, "pointer");
    end
    d = 8'($urandom);
    wr(8'hFF, d);
    repeat (3) @(posedge clk_i);
    stk_op_i <= csp_pkg::CSP_STK_PUSH;
    @(posedge clk_i);
    stk_op_i <= csp_pkg::CSP_STK_NONE;
    rd(8'hFF, v); chk(v, d - 8'h01, "push");
    @(posedge clk_i);
    stk_op_i <= csp_pkg::CSP_STK_POP;
    repeat (2) @(posedge clk_i);
    stk_op_i <= csp_pkg::CSP_STK_NONE;
    rd(8'hFF, v); chk(v, d + 8'h01, "pop");
    timer1_irq_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk(8'(interrupt_request_five_o), 8'h01, "timer request");
    wr(8'h0C, 8'hFF);
    rd(8'h0C, v); chk(v, exp_mon(1, 0), "monitor write");
    chk(8'(interrupt_request_five_o), 8'h00, "timer blocked");
    repeat (700) @(posedge clk_i);
    #1 chk(8'(lvd_settled_o), 8'h00, "not settled");
    repeat (150) @(posedge clk_i);
    #1 chk(8'(lvd_settled_o), 8'h01, "settled");
    comparator_trip_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    comparator_trip_i <= 1'b0;
    rd(8'h0C, v); chk(v, exp_mon(1, 1), "trip sticky");
    chk(8'(interrupt_request_five_o), 8'h01, "detect request");
    wr(8'h0C, 8'h00);
    stop_mode_i <= 1'b1;
    wr(8'h0C, 8'h01);
    comparator_trip_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(8'h0C, v); chk(v, exp_mon(1, 0), "stop idle");
    close_out();
  end
endmodule : csp_regs_tb
bind csp_regs csp_regs_checker csp_regs_checker_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .stk_op_i(stk_op_i), .work_reg_i(work_reg_i),
  .stop_mode_i(stop_mode_i), .timer1_irq_i(timer1_irq_i), .work_addr_o(work_addr_o),
  .expanded_register_bank_o(expanded_register_bank_o), .bank_valid_o(bank_valid_o), .stack_addr_o(stack_addr_o),
  .interrupt_request_five_o(interrupt_request_five_o), .lvd_settled_o(lvd_settled_o));
`default_nettype wire
